// ### design/pam_latch.sv
// Latching and acknowledge state of one alarm channel.
`timescale 1ns/10ps
module pam_latch import pam_pkg::*; (
	// Clock and reset.
	input wire logic core_clk_i,
	input wire logic rst_i,
	// Condition and operator acknowledge.
	input wire logic cond_i,
	input wire logic ack_i,
	input wire pam_latch_type mode_i,
	// Channel state.
	output logic active_o
);
	typedef struct packed {
		logic active;
		logic acked;
	} pam_lstate_type;

	pam_lstate_type s_q;
	pam_lstate_type s_d;

	always_comb begin
		s_d = s_q;
		case (mode_i)
			PAM_LATCH_NONE: begin
				s_d.active = cond_i;
				s_d.acked = 1'b0;
			end
			PAM_LATCH_AUTO: begin
				// An acknowledge taken during the condition holds the
				// alarm off until the condition has gone away once.
				if (ack_i) begin
					s_d.active = 1'b0;
					s_d.acked = cond_i;
				end else if (!cond_i) begin
					s_d.acked = 1'b0;
				end else if (!s_q.acked) begin
					s_d.active = 1'b1;
				end
			end
			default: begin
				s_d.acked = 1'b0;
				if (cond_i) begin
					s_d.active = 1'b1;
				end else if (ack_i) begin
					s_d.active = 1'b0;
				end
			end
		endcase
	end

	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign active_o = s_q.active;
endmodule : pam_latch

// ### design/pam_monitor.sv
// Alarm evaluation and annunciation top of the process alarm monitor.
//
// Summary of operation
// - Full-scale low: value below threshold alarms.
// - Full-scale high: value above threshold alarms.
// - Deviation low: below setpoint beyond threshold.
// - Deviation high: above setpoint beyond threshold.
// - Band: absolute deviation beyond threshold alarms.
// - Rising rate per minute above threshold.
// - Falling rate per minute above threshold.
// - Loop broken: value static after demand change.
// - Open sensor alarms and forces safe output.
// - Active alarm flashes beacon, reports source.
// - Assigned output follows its active alarm.
// - Default relay de-energises while alarm active.
// - Manual latch: needs clear condition and acknowledge.
// - Manual latch ignores acknowledge during condition.
// - Four independently configured alarm channels.
// - Acknowledge after clearing resets beacon, message, relay.
// - Non-latching alarm clears with its condition.
// - Auto latch accepts acknowledge during condition.
// - Manual control mode masks deviation, band alarms.
`timescale 1ns/10ps
module pam_monitor import pam_pkg::*; #(
	parameter int W = PV_W,
	parameter int NCH = NUM_CH,
	parameter longint RATE_CYC = RATE_WIN_CYC,
	parameter longint TICK_CYC = LOOP_TICK_CYC,
	parameter longint FLASH_CYC = FLASH_HALF_CYC
) (
	// Clock and reset.
	input wire logic core_clk_i,
	input wire logic rst_i,
	// Process measurement and control demand.
	input wire logic signed [W-1:0] pv_i,
	input wire logic signed [W-1:0] sp_i,
	input wire logic [W-1:0] demand_i,
	input wire logic [W-1:0] safe_level_i,
	input wire logic manual_mode_i,
	// Sensor open-circuit pin and operator acknowledge pin.
	input wire logic sensor_open_i,
	input wire logic ack_btn_i,
	// Per-channel configuration and the shared loop delay.
	input wire pam_alarm_type [NCH-1:0] alarm_type_i,
	input wire pam_latch_type [NCH-1:0] latch_mode_i,
	input wire logic signed [NCH-1:0][W-1:0] threshold_i,
	input wire logic [NCH-1:0] relay_energise_i,
	input wire logic [LOOP_W-1:0] loop_delay_i,
	// Annunciation and outputs.
	output logic alarm_beacon_o,
	output logic [MSG_W-1:0] alarm_source_o,
	output logic sensor_break_message_o,
	output logic loop_broken_o,
	output logic [NCH-1:0] alarm_active_o,
	output logic [NCH-1:0] relay_o,
	output logic [W-1:0] ctrl_out_o
);
	localparam logic [CNT_W-1:0] RATE_LAST = CNT_W'(RATE_CYC - 1);
	localparam logic [CNT_W-1:0] TICK_LAST = CNT_W'(TICK_CYC - 1);
	localparam logic [CNT_W-1:0] FLASH_LAST = CNT_W'(FLASH_CYC - 1);

	typedef struct packed {
		logic [2:0] ack_s;
		logic [2:0] brk_s;
		logic ack_lvl;
		logic brk_lvl;
		logic [CNT_W-1:0] rate_cnt;
		logic signed [W-1:0] pv_min;
		logic signed [W:0] rate;
		logic [CNT_W-1:0] tick_cnt;
		logic [LOOP_W-1:0] loop_cnt;
		logic loop_arm;
		logic signed [W-1:0] loop_pv;
		logic [W-1:0] dem_prev;
		logic loop_brk;
		logic [CNT_W-1:0] flash_cnt;
		logic flash;
		logic beacon;
		logic [NCH-1:0] active;
		logic [NCH-1:0] relay;
		logic [MSG_W-1:0] msg;
		logic [W-1:0] ctrl;
	} pam_state_type;

	pam_state_type s_q;
	pam_state_type s_d;
	logic [NCH-1:0] cond;
	logic [NCH-1:0] active;
	logic ack_pulse;

	// Evaluates one alarm condition; every compare is strict.
	function automatic logic eval_alarm(input pam_alarm_type typ,
			input logic signed [W-1:0] pv, input logic signed [W-1:0] sp,
			input logic signed [W-1:0] thr, input logic signed [W:0] rate,
			input logic man);
		logic signed [W+1:0] dev;
		logic signed [W+1:0] th;
		logic signed [W+1:0] rt;
		logic hit;
		dev = (W+2)'(pv) - (W+2)'(sp);
		th = (W+2)'(thr);
		rt = (W+2)'(rate);
		case (typ)
			PAM_FS_LOW: hit = pv < thr;
			PAM_FS_HIGH: hit = pv > thr;
			PAM_DEV_LOW: hit = !man && (-dev > th);
			PAM_DEV_HIGH: hit = !man && (dev > th);
			PAM_DEV_BAND: hit = !man && (dev > th || -dev > th);
			PAM_RATE_RISE: hit = rt > th;
			PAM_RATE_FALL: hit = -rt > th;
			default: hit = 1'b0;
		endcase
		return hit;
	endfunction : eval_alarm

	// Names the alarm to report; sensor break outranks loop break,
	// which outranks the lowest-numbered channel.
	function automatic logic [MSG_W-1:0] pick_source(
			input logic [NCH-1:0] act, input logic lb, input logic sb);
		logic [MSG_W-1:0] src;
		src = MSG_NONE;
		for (int i = NCH - 1; i >= 0; i--) begin
			if (act[i]) begin
				src = MSG_W'(i + 1);
			end
		end
		if (lb) begin
			src = MSG_LOOP_BROKEN;
		end
		if (sb) begin
			src = MSG_SENSOR_BREAK;
		end
		return src;
	endfunction : pick_source

	assign ack_pulse = s_q.ack_s[1] && s_q.ack_s[2] && !s_q.ack_lvl;

	genvar g;
	generate
		for (g = 0; g < NCH; g++) begin : g_ch
			assign cond[g] = eval_alarm(alarm_type_i[g], pv_i, sp_i,
				threshold_i[g], s_q.rate, manual_mode_i);
			pam_latch u_latch (
				.core_clk_i(core_clk_i),
				.rst_i(rst_i),
				.cond_i(cond[g]),
				.ack_i(ack_pulse),
				.mode_i(latch_mode_i[g]),
				.active_o(active[g])
			);
		end
	endgenerate

	always_comb begin
		s_d = s_q;
		s_d.ack_s = {s_q.ack_s[1:0], ack_btn_i};
		s_d.brk_s = {s_q.brk_s[1:0], sensor_open_i};
		// A pin level is taken once the second and third stages agree.
		if (s_q.ack_s[1] == s_q.ack_s[2]) begin
			s_d.ack_lvl = s_q.ack_s[2];
		end
		if (s_q.brk_s[1] == s_q.brk_s[2]) begin
			s_d.brk_lvl = s_q.brk_s[2];
		end
		// Rate is the change of value over the last full minute.
		if (s_q.rate_cnt == RATE_LAST) begin
			s_d.rate_cnt = '0;
			s_d.pv_min = pv_i;
			s_d.rate = (W+1)'(pv_i) - (W+1)'(s_q.pv_min);
		end else begin
			s_d.rate_cnt = s_q.rate_cnt + 1'b1;
		end
		if (s_q.tick_cnt == TICK_LAST) begin
			s_d.tick_cnt = '0;
		end else begin
			s_d.tick_cnt = s_q.tick_cnt + 1'b1;
		end
		// Loop supervision restarts on every demand change.
		s_d.dem_prev = demand_i;
		if (demand_i != s_q.dem_prev) begin
			s_d.loop_arm = 1'b1;
			s_d.loop_cnt = '0;
			s_d.loop_pv = pv_i;
		end else if (pv_i != s_q.loop_pv) begin
			s_d.loop_arm = 1'b0;
			s_d.loop_brk = 1'b0;
		end else if (s_q.loop_arm && s_q.tick_cnt == TICK_LAST) begin
			if (s_q.loop_cnt >= loop_delay_i) begin
				s_d.loop_brk = !s_q.brk_lvl;
				s_d.loop_arm = 1'b0;
			end else begin
				s_d.loop_cnt = s_q.loop_cnt + 1'b1;
			end
		end
		// Open sensor forces the configured safe level on the output.
		s_d.ctrl = s_q.brk_lvl ? safe_level_i : demand_i;
		if (s_q.flash_cnt == FLASH_LAST) begin
			s_d.flash_cnt = '0;
			s_d.flash = !s_q.flash;
		end else begin
			s_d.flash_cnt = s_q.flash_cnt + 1'b1;
		end
		s_d.active = active;
		if (|active || s_q.loop_brk || s_q.brk_lvl) begin
			s_d.beacon = s_q.flash;
		end else begin
			s_d.beacon = 1'b0;
		end
		s_d.msg = pick_source(active, s_q.loop_brk, s_q.brk_lvl);
		// With energise clear, the relay drops out in alarm and stays
		// pulled in when quiet, so a power loss also shows as alarm.
		s_d.relay = active ^ ~relay_energise_i;
	end

	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign alarm_beacon_o = s_q.beacon;
	assign alarm_source_o = s_q.msg;
	assign sensor_break_message_o = s_q.brk_lvl;
	assign loop_broken_o = s_q.loop_brk;
	assign alarm_active_o = s_q.active;
	assign relay_o = s_q.relay;
	assign ctrl_out_o = s_q.ctrl;
endmodule : pam_monitor

// ### design/pam_pkg.sv
// Shared constants and types of the process alarm monitor.
package pam_pkg;
	localparam int NUM_CH = 4;
	localparam int NUM_BASIC_CH = 2;
	localparam int PV_W = 16;
	localparam int CNT_W = 40;
	localparam int LOOP_W = 16;
	localparam int MSG_W = 3;
	localparam longint CLK_HZ = 64'd200_000_000;
	localparam longint RATE_WIN_S = 64'd60;
	localparam longint LOOP_TICK_S = 64'd1;
	localparam longint FLASH_HALF_MS = 64'd500;
	localparam longint RATE_WIN_CYC = RATE_WIN_S * CLK_HZ;
	localparam longint LOOP_TICK_CYC = LOOP_TICK_S * CLK_HZ;
	localparam longint FLASH_HALF_CYC = FLASH_HALF_MS * CLK_HZ / 64'd1000;
	localparam logic [MSG_W-1:0] MSG_NONE = 3'h0;
	localparam logic [MSG_W-1:0] MSG_LOOP_BROKEN = 3'h5;
	localparam logic [MSG_W-1:0] MSG_SENSOR_BREAK = 3'h6;
	localparam logic [2:0] SYNC_RST = 3'h0;
	typedef enum logic [2:0] {
		PAM_OFF = 3'h0,
		PAM_FS_LOW = 3'h1,
		PAM_FS_HIGH = 3'h3,
		PAM_DEV_LOW = 3'h2,
		PAM_DEV_HIGH = 3'h6,
		PAM_DEV_BAND = 3'h7,
		PAM_RATE_RISE = 3'h5,
		PAM_RATE_FALL = 3'h4
	} pam_alarm_type;
	typedef enum logic [1:0] {
		PAM_LATCH_MANUAL = 2'h0,
		PAM_LATCH_AUTO = 2'h1,
		PAM_LATCH_NONE = 2'h3
	} pam_latch_type;
endpackage : pam_pkg

// ### sim/pam_checker.sv
// Assertion checker bound to the process alarm monitor.
`timescale 1ns/10ps
module pam_checker import pam_pkg::*; #(
	parameter int W = PV_W,
	parameter int NCH = NUM_CH
) (
	// Monitor inputs.
	input wire logic core_clk_i,
	input wire logic rst_i,
	input wire logic signed [W-1:0] pv_i,
	input wire logic sensor_open_i,
	input wire pam_alarm_type [NCH-1:0] alarm_type_i,
	input wire pam_latch_type [NCH-1:0] latch_mode_i,
	input wire logic signed [NCH-1:0][W-1:0] threshold_i,
	input wire logic [NCH-1:0] relay_energise_i,
	// Monitor outputs.
	input wire logic alarm_beacon_o,
	input wire logic [MSG_W-1:0] alarm_source_o,
	input wire logic sensor_break_message_o,
	input wire logic loop_broken_o,
	input wire logic [NCH-1:0] alarm_active_o,
	input wire logic [NCH-1:0] relay_o
);
	default clocking @(posedge core_clk_i);
	endclocking
	default disable iff (rst_i);
	property p_low;
		alarm_type_i[0] == PAM_FS_LOW && latch_mode_i[0] != PAM_LATCH_AUTO &&
			pv_i < threshold_i[0] |-> ##2 alarm_active_o[0];
	endproperty
	a_low: assert property (p_low) else $error("low alarm missing");
	property p_relay;
		!$past(rst_i) |-> relay_o == (alarm_active_o ^ ~$past(relay_energise_i));
	endproperty
	a_relay: assert property (p_relay) else $error("relay level");
	property p_src;
		alarm_active_o[0] && !sensor_break_message_o && !loop_broken_o |->
			alarm_source_o == 3'h1;
	endproperty
	a_src: assert property (p_src) else $error("source id");
	property p_dark;
		(alarm_source_o == MSG_NONE)[*2] |-> !alarm_beacon_o;
	endproperty
	a_dark: assert property (p_dark) else $error("beacon lit");
	property p_flash;
		not (alarm_source_o != MSG_NONE && $stable(alarm_beacon_o))[*6];
	endproperty
	a_flash: assert property (p_flash) else $error("beacon still");
	property p_open;
		sensor_open_i[*5] |-> ##1 sensor_break_message_o;
	endproperty
	a_open: assert property (p_open) else $error("no break flag");
	property p_sbsrc;
		sensor_break_message_o[*2] |-> alarm_source_o == MSG_SENSOR_BREAK;
	endproperty
	a_sbsrc: assert property (p_sbsrc) else $error("break source");
	property p_loop;
		(loop_broken_o && !sensor_break_message_o)[*2] |->
			alarm_source_o == MSG_LOOP_BROKEN;
	endproperty
	a_loop: assert property (p_loop) else $error("loop source");
	c_flash: cover property (alarm_beacon_o ##1 !alarm_beacon_o);
	c_loop: cover property ($rose(loop_broken_o));
	c_clear: cover property ($fell(alarm_active_o[1]));
endmodule : pam_checker
bind pam_monitor pam_checker #(.W(W), .NCH(NCH)) pam_checker_i (.*);

// ### sim/pam_partner.sv
// Operator button and sensor pin model facing the alarm monitor.
`timescale 1ns/10ps
module pam_partner (
	// Bench requests.
	input wire logic core_clk_i,
	input wire logic press_i,
	input wire logic open_i,
	// Pins.
	output logic ack_btn_o = 1'h0,
	output logic sensor_open_o = 1'h0
);
	int hold = 0;
	// A press is held four cycles so that the pin filter passes it.
	always @(negedge core_clk_i) begin
		hold = press_i ? 4 : hold - int'(hold > 0);
		ack_btn_o <= hold > 0;
		sensor_open_o <= open_i;
	end
endmodule : pam_partner

// ### sim/tb.sv
// Self-checking testbench of the process alarm monitor.
`timescale 1ns/10ps
module tb import pam_pkg::*; ();
	logic core_clk_i = 0, rst_i = 1, manual_mode_i = 0, press = 0, open = 0;
	logic signed [15:0] pv_i = 16'h0064, sp_i = 16'h0064;
	logic [15:0] demand_i = '0, safe_level_i = '0, loop_delay_i = 16'h0003;
	logic ack_btn_i, sensor_open_i, alarm_beacon_o, sensor_break_message_o;
	logic loop_broken_o;
	logic [2:0] alarm_source_o;
	logic [3:0] relay_energise_i = '0, alarm_active_o, relay_o, ev;
	logic [15:0] ctrl_out_o;
	logic signed [3:0][15:0] threshold_i = '0;
	pam_alarm_type [3:0] alarm_type_i = {4{PAM_OFF}};
	pam_latch_type [3:0] latch_mode_i = {4{PAM_LATCH_NONE}};
	pam_alarm_type kinds[6] = '{PAM_FS_LOW, PAM_FS_HIGH, PAM_DEV_LOW,
		PAM_DEV_HIGH, PAM_DEV_BAND, PAM_OFF};
	logic [5:0] q[$];
	logic [5:0] e;
	int n_mismatch = 0, n_compared = 0;
	event chk;
	pam_monitor #(.RATE_CYC(50), .TICK_CYC(4), .FLASH_CYC(4)) pam_monitor_i (.*);
	pam_partner pam_partner_i (.core_clk_i, .press_i(press), .open_i(open),
		.ack_btn_o(ack_btn_i), .sensor_open_o(sensor_open_i));
	always #2.5 core_clk_i = ~core_clk_i;
	task automatic cyc(int n);
		repeat (n) @(negedge core_clk_i);
	endtask : cyc
	task automatic note(logic [1:0] k, logic [3:0] x);
		q.push_back({k, x});
		->chk;
	endtask : note
	task automatic bad(string s);
		n_mismatch++;
		$display("Error at %0t: %s", $time, s);
	endtask : bad
	task automatic cmp_act(logic [3:0] x);
		n_compared++;
		if (alarm_active_o !== x) bad("active channels");
	endtask : cmp_act
	task automatic cmp_src(logic [2:0] x);
		n_compared++;
		if (alarm_source_o !== x) bad("alarm source");
	endtask : cmp_src
	task automatic cmp_flag(logic [1:0] x);
		n_compared++;
		if ({loop_broken_o, sensor_break_message_o} !== x) bad("flags");
	endtask : cmp_flag
	task automatic cmp_ctrl(logic x);
		n_compared++;
		if (ctrl_out_o !== (x ? safe_level_i : demand_i)) bad("control out");
	endtask : cmp_ctrl
	always @(chk) begin
		while (q.size() > 0) begin
			e = q.pop_front();
			case (e[5:4])
				2'h0: cmp_act(e[3:0]);
				2'h1: cmp_src(e[2:0]);
				2'h2: cmp_flag(e[1:0]);
				default: cmp_ctrl(e[0]);
			endcase
		end
	end
	task automatic ack();
		press <= 1'h1;
		cyc(1);
		press <= 1'h0;
		cyc(14);
	endtask : ack
	function automatic logic hit(pam_alarm_type t, int pv, int th);
		case (t)
			PAM_FS_LOW: return pv < th;
			PAM_FS_HIGH: return pv > th;
			PAM_DEV_LOW: return !manual_mode_i && 100 - pv > th;
			PAM_DEV_HIGH: return !manual_mode_i && pv - 100 > th;
			PAM_DEV_BAND: return !manual_mode_i && (pv - 100 > th || 100 - pv > th);
			default: return 1'h0;
		endcase
	endfunction : hit
	task automatic end_of_test();
		$display("compared %0d, mismatches %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : end_of_test
	initial begin
		#10000;
		bad("watchdog expired");
		end_of_test();
	end
	initial begin
		int v;
		v = $urandom(32'hc220);
		cyc(2);
		rst_i = 0;
		cyc(2);
		for (int i = 0; i < 40; i++) begin
			pv_i = 16'(85 + $urandom_range(30));
			manual_mode_i = 1'($urandom_range(1));
			relay_energise_i = 4'($urandom);
			safe_level_i = 16'($urandom);
			for (int k = 0; k < 4; k++) begin
				alarm_type_i[k] = kinds[(i + k) % 6];
				threshold_i[k] = (i + k) % 6 < 2 ? 16'h0064 : 16'h000a;
				ev[k] = hit(alarm_type_i[k], pv_i, threshold_i[k]);
			end
			cyc(3);
			note(0, ev);
		end
		$display("channel test done");
		alarm_type_i = {4{PAM_OFF}};
		threshold_i[1] = 16'h0069;
		for (int m = 0; m < 2; m++) begin
			latch_mode_i[1] = m ? PAM_LATCH_AUTO : PAM_LATCH_MANUAL;
			alarm_type_i[1] = PAM_FS_HIGH;
			pv_i = 16'h0078;
			cyc(4);
			note(0, 4'h2);
			note(1, 4'h2);
			ack();
			note(0, m ? 4'h0 : 4'h2);
			pv_i = 16'h0064;
			cyc(4);
			ack();
			note(0, 4'h0);
		end
		alarm_type_i = {4{PAM_OFF}};
		latch_mode_i = {4{PAM_LATCH_NONE}};
		$display("latch test done");
		for (int s = 1; s >= 0; s--) begin
			open = 1'(s);
			cyc(8);
			note(2, 4'(s));
			note(3, 4'(s));
			note(1, s ? 4'h6 : 4'h0);
		end
		alarm_type_i[2] = PAM_RATE_FALL;
		alarm_type_i[3] = PAM_RATE_RISE;
		threshold_i[3:2] = {2{16'h0014}};
		for (int d = -1; d < 2; d += 2) begin
			repeat (150) begin
				pv_i = pv_i + 16'(d);
				cyc(1);
			end
			cyc(3);
			note(0, d > 0 ? 4'h8 : 4'h4);
			cyc(110);
			note(0, 4'h0);
		end
		$display("rate test done");
		demand_i = 16'h0100;
		cyc(40);
		note(2, 4'h2);
		note(1, 4'h5);
		pv_i = pv_i + 16'h0001;
		cyc(4);
		note(2, 4'h0);
		$display("loop test done");
		end_of_test();
	end
endmodule : tb
